// file: verilog/rtc_pkg.sv
// Constants, field positions and types shared by the timekeeper files.
// Assumes one 50 MHz system clock; no bus beyond the three-wire link.
package rtc_pkg;
	localparam int OSC_RATE = 32768;
	localparam int NUM_TREG = 7;
	localparam int RAM_WORDS = 31;
	localparam int REG_SEC = 0;
	localparam int REG_MIN = 1;
	localparam int REG_HR = 2;
	localparam int REG_DATE = 3;
	localparam int REG_MON = 4;
	localparam int REG_DOW = 5;
	localparam int REG_YR = 6;
	localparam int CMD_ONE = 7;
	localparam int CMD_SPACE = 6;
	localparam int CMD_READ = 0;
	localparam int SEC_HALT = 7;
	localparam int HR_MODE = 7;
	localparam int HR_PM = 5;
	localparam int WP_BIT = 7;
	localparam logic [4:0] IDX_CTRL = 5'h07;
	localparam logic [4:0] IDX_CHG = 5'h08;
	localparam logic [4:0] IDX_RAM_LAST = 5'h1E;
	localparam logic [4:0] IDX_BURST = 5'h1F;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [6:0] LOAD_ALL = 7'h7F;
	localparam logic [3:0] CHG_KEY = 4'hA;
	localparam logic [1:0] DS_ONE = 2'h1;
	localparam logic [1:0] DS_TWO = 2'h2;
	localparam logic [1:0] RS_NONE = 2'h0;
	localparam logic [7:0] CHG_RESET = 8'h5C;
	localparam logic WP_RESET = 1'b0;
	localparam logic [7:0] SEC_RESET = 8'h80;
	localparam logic [7:0] BCD_ZERO = 8'h00;
	localparam logic [7:0] BCD_ONE = 8'h01;
	localparam logic [3:0] BCD_NINE = 4'h9;
	localparam logic [7:0] SEC_LAST = 8'h59;
	localparam logic [7:0] HR24_LAST = 8'h23;
	localparam logic [7:0] HR12_ELEVEN = 8'h11;
	localparam logic [7:0] HR12_LAST = 8'h12;
	localparam logic [7:0] DOW_LAST = 8'h07;
	localparam logic [7:0] MON_LAST = 8'h12;
	localparam logic [7:0] YR_LAST = 8'h99;
	localparam logic [7:0] MON_FEB = 8'h02;
	localparam logic [7:0] MON_APR = 8'h04;
	localparam logic [7:0] MON_JUN = 8'h06;
	localparam logic [7:0] MON_SEP = 8'h09;
	localparam logic [7:0] MON_NOV = 8'h11;
	localparam logic [7:0] DAY_28 = 8'h28;
	localparam logic [7:0] DAY_29 = 8'h29;
	localparam logic [7:0] DAY_30 = 8'h30;
	localparam logic [7:0] DAY_31 = 8'h31;
	typedef logic [NUM_TREG-1:0][7:0] tbuf_t;
endpackage : rtc_pkg

// file: verilog/time_if.sv
// Carries time between the serial front end and the calendar counters.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface time_if;
	import rtc_pkg::*;
	tbuf_t now;
	tbuf_t wdata;
	logic [NUM_TREG-1:0] load;
	modport cal(input wdata, input load, output now);
	modport ctl(output wdata, output load, input now);
endinterface : time_if
`default_nettype wire

// file: verilog/rtc_calendar.sv
// BCD clock and calendar counters driven by the 32.768 kHz oscillator pin.
// Assumes loads arrive as one-cycle masks from the serial front end.
`timescale 1ns/1ps
`default_nettype none
module rtc_calendar import rtc_pkg::*; #(
	parameter int OSC_HZ = OSC_RATE
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic osc_in,
	time_if.cal tif
);
	localparam logic [14:0] DIV_LAST = 15'(OSC_HZ - 1);
	typedef struct packed {
		logic [2:0] osc_s;
		logic osc_f;
		logic [14:0] div;
		tbuf_t t;
	} cal_s;
	cal_s q;
	cal_s d;

	function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] lo,
		input logic [7:0] hi);
		if (v >= hi) return {1'b1, lo};
		if (v[3:0] == BCD_NINE) return {1'b0, v[7:4] + 4'h1, 4'h0};
		return {1'b0, v + 8'h01};
	endfunction : bcd_inc

	// R17: twelve or twenty-four hour step
	function automatic logic [8:0] hr_inc(input logic [7:0] h);
		logic [8:0] x;
		x = bcd_inc({3'h0, h[4:0]}, BCD_ZERO, HR12_LAST);
		if (!h[HR_MODE]) return bcd_inc(h, BCD_ZERO, HR24_LAST);
		if (h[4:0] == HR12_ELEVEN[4:0]) return {h[HR_PM], h[7:6], ~h[HR_PM], HR12_LAST[4:0]};
		if (h[4:0] == HR12_LAST[4:0]) return {1'b0, h[7:5], BCD_ONE[4:0]};
		return {1'b0, h[7:5], x[4:0]};
	endfunction : hr_inc

	// R23: month length with leap years
	function automatic logic [7:0] mdays(input logic [7:0] m, input logic [7:0] y);
		logic leap;
		leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
			: (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
		if (m == MON_FEB) return leap ? DAY_29 : DAY_28;
		if (m == MON_APR || m == MON_JUN || m == MON_SEP || m == MON_NOV) return DAY_30;
		return DAY_31;
	endfunction : mdays

	always_comb begin
		logic [8:0] r;
		logic osc_n;
		r = '0;
		d = q;
		d.osc_s = {q.osc_s[1:0], osc_in};
		osc_n = (q.osc_s[1] == q.osc_s[2]) ? q.osc_s[2] : q.osc_f;
		d.osc_f = osc_n;
		// R18: halt freezes the divider
		// R24: one second from oscillator edges
		if (osc_n && !q.osc_f && !q.t[REG_SEC][SEC_HALT]) begin
			d.div = 15'(q.div + 15'h1);
			if (q.div == DIV_LAST) begin
				d.div = '0;
				r = bcd_inc(q.t[REG_SEC], BCD_ZERO, SEC_LAST);
				d.t[REG_SEC] = r[7:0];
				if (r[8]) begin
					r = bcd_inc(q.t[REG_MIN], BCD_ZERO, SEC_LAST);
					d.t[REG_MIN] = r[7:0];
				end
				if (r[8]) begin
					r = hr_inc(q.t[REG_HR]);
					d.t[REG_HR] = r[7:0];
				end
				if (r[8]) begin
					// R13: weekday steps at midnight
					d.t[REG_DOW] = 8'(bcd_inc(q.t[REG_DOW], BCD_ONE, DOW_LAST));
					r = bcd_inc(q.t[REG_DATE], BCD_ONE, mdays(q.t[REG_MON], q.t[REG_YR]));
					d.t[REG_DATE] = r[7:0];
				end
				if (r[8]) begin
					r = bcd_inc(q.t[REG_MON], BCD_ONE, MON_LAST);
					d.t[REG_MON] = r[7:0];
				end
				if (r[8]) begin
					d.t[REG_YR] = 8'(bcd_inc(q.t[REG_YR], BCD_ZERO, YR_LAST));
				end
			end
		end
		for (int i = 0; i < NUM_TREG; i++) begin
			if (tif.load[i]) begin
				d.t[i] = tif.wdata[i];
			end
		end
		// R16: seconds write restarts the divider
		if (tif.load[REG_SEC]) begin
			d.div = '0;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			q <= '0;
			q.t[REG_SEC] <= SEC_RESET;
			q.t[REG_DATE] <= BCD_ONE;
			q.t[REG_MON] <= BCD_ONE;
			q.t[REG_DOW] <= BCD_ONE;
		end else begin
			q <= d;
		end
	end

	assign tif.now = q.t;

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	a_sec_div_reset: assert property (tif.load[REG_SEC] |=> q.div == '0) // R16
		else $error("divider not cleared by seconds write");
	a_halt_holds_time: assert property ( // R18
		(q.t[REG_SEC][SEC_HALT] && tif.load == '0) |=> $stable(q.t))
		else $error("time moved while halted");
endmodule : rtc_calendar
`default_nettype wire

// file: verilog/rtc_serial_top.sv
// Three-wire serial front end, user buffers, scratch RAM and charger setup.
// Assumes ce, sclk and io_in come asynchronously from the host pins.
//
// Functional notes
// R01: Command bit 7 must be one; otherwise the transaction writes nothing.
// R02: Bit 6 picks clock or RAM, bits 5..1 index, bit 0 reads.
// R03: Command byte arrives least significant bit first.
// R04: Enable low aborts any transfer and floats the data pin.
// R05: Inputs sampled on sclk rise, outputs driven on sclk fall.
// R06: Host keeps sclk low while raising the enable.
// R07: Write command takes one data byte, later cycles ignored.
// R08: Read data bit 0 leaves on the first fall after the command.
// R09: Extra read cycles keep sending bytes; pin released on every rise.
// R10: Index 31 means burst, starting at register 0 and stepping up.
// R11: Clock burst write commits only after all eight registers; no charger.
// R12: Each complete RAM burst byte is stored at once.
// R13: Time is BCD; weekday advances at midnight.
// R14: Time reads come from a buffer loaded at enable rise.
// R15: Time writes move from buffer into counters at enable fall.
// R16: Seconds write clears the sub-second divider.
// R17: Hours bit 7 picks twelve hour mode; bit 5 is PM or twenty.
// R18: Seconds bit 7 halts the clock; zero lets it run.
// R19: Control bit 7 locks writes to all other registers; rest read zero.
// R20: Locked clock burst write updates none of the eight registers.
// R21: Charger on only with key 1010 in bits 7..4; reset disables it.
// R22: Diode field 01 or 10, resistor field nonzero, else charger off.
// R23: Date wraps correctly for short months and leap years.
// R24: Oscillator edges form the one second time base.
// R25: Enable rise clears bit and byte counters.
// R26: Unbacked indices read zero and swallow writes.
`timescale 1ns/1ps
`default_nettype none
module rtc_serial_top import rtc_pkg::*; #(
	parameter int OSC_HZ = OSC_RATE
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic sclk,
	input wire logic io_in,
	input wire logic osc_in,
	output logic io_out,
	output logic io_oe,
	output logic charger_on,
	output logic charger_two_diodes,
	output logic [1:0] charger_resistor
);
	typedef struct packed {
		logic [2:0] ce_s;
		logic [2:0] sck_s;
		logic [2:0] dat_s;
		logic ce_f;
		logic sck_f;
		logic dat_f;
		logic cmd_done;
		logic done;
		logic wen;
		logic burst;
		logic full;
		logic [2:0] cnt;
		logic [7:0] cmd;
		logic [7:0] sh;
		logic [4:0] idx;
		logic wp;
		logic wp_pend;
		logic io_out;
		logic io_oe;
		logic [7:0] tc;
		logic [3:0] chg;
		logic [NUM_TREG-1:0] dirty;
		logic [NUM_TREG-1:0] load;
		tbuf_t ubuf;
		logic [RAM_WORDS-1:0][7:0] ram;
	} ser_s;

	ser_s q;
	ser_s d;
	logic ce_rise;
	logic ce_fall;
	logic sck_rise;
	logic sck_fall;

	time_if tif();

	rtc_calendar #(
		.OSC_HZ(OSC_HZ)
	) u_cal (
		.clk(clk),
		.srst(srst),
		.osc_in(osc_in),
		.tif(tif)
	);

	assign tif.load = q.load;
	assign tif.wdata = q.ubuf;

	always_comb begin
		logic ce_n;
		logic sck_n;
		logic dat_n;
		logic space;
		logic [7:0] nb;
		logic [7:0] rd_b;
		logic [7:0] ob;
		logic [4:0] cidx;
		ce_n = (q.ce_s[1] == q.ce_s[2]) ? q.ce_s[2] : q.ce_f;
		sck_n = (q.sck_s[1] == q.sck_s[2]) ? q.sck_s[2] : q.sck_f;
		dat_n = (q.dat_s[1] == q.dat_s[2]) ? q.dat_s[2] : q.dat_f;
		space = q.cmd[CMD_SPACE];
		nb = {dat_n, q.sh[7:1]};
		cidx = nb[5:1];
		ob = '0;
		d = q;
		d.ce_s = {q.ce_s[1:0], ce};
		d.sck_s = {q.sck_s[1:0], sclk};
		d.dat_s = {q.dat_s[1:0], io_in};
		d.ce_f = ce_n;
		d.sck_f = sck_n;
		d.dat_f = dat_n;
		d.load = '0;
		ce_rise = ce_n && !q.ce_f;
		ce_fall = !ce_n && q.ce_f;
		sck_rise = ce_n && sck_n && !q.sck_f;
		sck_fall = ce_n && !sck_n && q.sck_f;

		// R26: unbacked indices read as zero
		rd_b = '0;
		if (space) begin
			if (q.idx <= IDX_RAM_LAST) begin
				rd_b = q.ram[q.idx];
			end
		end else if (q.idx < IDX_CTRL) begin
			rd_b = q.ubuf[q.idx[2:0]];
		end else if (q.idx == IDX_CTRL) begin
			// R19: lower control bits read zero
			rd_b = {q.wp, 7'h00};
		end else if (q.idx == IDX_CHG) begin
			rd_b = q.tc;
		end

		// R22: charger needs a legal diode and resistor choice
		// R21: charger key pattern
		d.chg[3] = (q.tc[7:4] == CHG_KEY) && (q.tc[3:2] == DS_ONE || q.tc[3:2] == DS_TWO)
			&& (q.tc[1:0] != RS_NONE);
		d.chg[2] = (q.tc[3:2] == DS_TWO);
		d.chg[1:0] = q.tc[1:0];

		if (ce_rise) begin
			// R25: fresh count, next cycle is command bit 0
			// R06: host holds sclk low here, so no edge is lost
			d.cnt = '0;
			d.cmd_done = 1'b0;
			d.done = 1'b0;
			d.full = 1'b0;
			d.dirty = '0;
			// R14: snapshot running time for reads
			d.ubuf = tif.now;
		end

		if (ce_fall) begin
			// R15: commit buffered time at enable fall
			// R11: burst commits only when all eight arrived
			d.load = q.dirty | (q.full ? LOAD_ALL : '0);
			if (q.full) begin
				d.wp = q.wp_pend;
			end
			d.dirty = '0;
			d.full = 1'b0;
		end

		if (!ce_n) begin
			// R04: drop the pin whenever enable is low
			d.io_oe = 1'b0;
		end else if (sck_rise) begin
			// R09: release the pin on each rise
			d.io_oe = 1'b0;
			if (!q.cmd_done) begin
				// R03: shift in command LSB first
				// R05: sample on the rising edge
				d.sh = nb;
				d.cnt = 3'(q.cnt + 3'h1);
				if (q.cnt == BIT_LAST) begin
					// R02: decode space, index and direction
					d.cmd = nb;
					d.cmd_done = 1'b1;
					// R10: index 31 starts a burst at register 0
					d.burst = (cidx == IDX_BURST);
					d.idx = (cidx == IDX_BURST) ? '0 : cidx;
					// R01: top bit zero blocks all writes
					d.wen = nb[CMD_ONE] && !q.wp;
				end
			end else if (!q.cmd[CMD_READ] && !q.done) begin
				d.sh = nb;
				d.cnt = 3'(q.cnt + 3'h1);
				if (q.cnt == BIT_LAST) begin
					if (space) begin
						// R12: each whole RAM byte is stored now
						if (q.wen && q.idx <= IDX_RAM_LAST) begin
							d.ram[q.idx] = nb;
						end
					end else if (q.burst) begin
						// R20: lock at start blocks the whole burst
						if (q.wen) begin
							if (q.idx == IDX_CTRL) begin
								d.wp_pend = nb[WP_BIT];
								d.full = 1'b1;
							end else begin
								d.ubuf[q.idx[2:0]] = nb;
							end
						end
					end else if (q.idx < IDX_CTRL) begin
						if (q.wen) begin
							d.ubuf[q.idx[2:0]] = nb;
							d.dirty[q.idx[2:0]] = 1'b1;
						end
					end else if (q.idx == IDX_CTRL) begin
						// R19: lock itself stays writable
						if (q.cmd[CMD_ONE]) begin
							d.wp = nb[WP_BIT];
						end
					end else if (q.idx == IDX_CHG) begin
						if (q.wen) begin
							d.tc = nb;
						end
					end
					// R07: single byte write then ignore the rest
					if (!q.burst) begin
						d.done = 1'b1;
					end else if (space ? (q.idx == IDX_RAM_LAST) : (q.idx == IDX_CTRL)) begin
						// R11: clock burst stops before the charger
						d.done = 1'b1;
					end else begin
						d.idx = 5'(q.idx + 5'h01);
					end
				end
			end
		end else if (sck_fall && q.cmd_done && q.cmd[CMD_READ]) begin
			// R08: drive next bit on the falling edge
			ob = (q.cnt == '0) ? rd_b : q.sh;
			d.io_out = ob[0];
			d.sh = {1'b0, ob[7:1]};
			d.io_oe = 1'b1;
			d.cnt = 3'(q.cnt + 3'h1);
			// R09: further cycles send the next byte
			if (q.cnt == BIT_LAST && q.burst) begin
				if (space ? (q.idx == IDX_RAM_LAST) : (q.idx == IDX_CTRL)) begin
					d.idx = '0;
				end else begin
					d.idx = 5'(q.idx + 5'h01);
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			q <= '0;
			q.tc <= CHG_RESET;
			q.wp <= WP_RESET;
		end else begin
			q <= d;
		end
	end

	assign io_out = q.io_out;
	assign io_oe = q.io_oe;
	assign charger_on = q.chg[3];
	assign charger_two_diodes = q.chg[2];
	assign charger_resistor = q.chg[1:0];

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	sequence s_rd_fall;
		sck_fall && q.cmd_done && q.cmd[CMD_READ];
	endsequence

	sequence s_cmd_end;
		sck_rise && !q.cmd_done && q.cnt == BIT_LAST;
	endsequence

	// R04: enable low keeps the pin released
	a_ce_low_float: assert property (!q.ce_f |-> !q.io_oe) // R04
		else $error("data pin driven with enable low");
	// R09: each rising sclk releases the pin
	a_rise_release: assert property (sck_rise |=> !q.io_oe) // R09
		else $error("data pin still driven after sclk rise");
	// R25: enable rise restarts the command
	a_cmd_restart: assert property (ce_rise |=> (q.cnt == '0 && !q.cmd_done)) // R25
		else $error("counters not cleared at enable rise");
	// R08: read bits leave on falls
	a_rd_drive: assert property (s_rd_fall |=> q.io_oe) // R08
		else $error("read bit not driven on sclk fall");
	// R02: command decode after eighth bit
	a_cmd_decode: assert property (s_cmd_end |=> (q.cmd_done && q.cnt == '0)) // R02
		else $error("command byte not taken after eight bits");
	// R19: RAM changes only when unlocked
	a_lock_ram: assert property ($changed(q.ram) |-> $past(q.wen)) // R19
		else $error("RAM written while locked or command invalid");
	// R11: full load only after a complete burst
	a_burst_all: assert property ((q.load == LOAD_ALL) |-> $past(q.full)) // R11
		else $error("clock burst committed before eight bytes");
	// R15: counters load only at enable fall
	a_commit_fall: assert property ((q.load != '0) |-> $past(ce_fall)) // R15
		else $error("time load outside enable fall");
	// R21: charger on only with the key
	a_charger_key: assert property (q.chg[3] |-> $past(q.tc[7:4] == CHG_KEY)) // R21
		else $error("charger enabled without key");

	sequence s_wr_last;
		sck_rise && q.cmd_done && !q.cmd[CMD_READ] && !q.done && q.cnt == BIT_LAST;
	endsequence

	// R01: writes need command bit 7
	a_wen_needs_one: assert property ((q.cmd_done && q.wen) |-> q.cmd[CMD_ONE]) // R01
		else $error("write enabled without command bit 7");
	// R19: charger register obeys the lock
	a_lock_charger: assert property ($changed(q.tc) |-> $past(q.wen)) // R19
		else $error("charger register written while locked");
	// R14: snapshot taken at enable rise
	a_snap_rise: assert property (ce_rise |=> q.ubuf == $past(tif.now)) // R14
		else $error("read buffer not loaded at enable rise");
	// R07: single write ends after one byte
	a_single_done: assert property (s_wr_last ##0 !q.burst |=> q.done) // R07
		else $error("single write not closed after one byte");
	// R07: later cycles change nothing
	a_done_ignore: assert property ((q.done && sck_rise) |=> // R07
		($stable(q.ram) && $stable(q.tc) && $stable(q.cnt)))
		else $error("cycles after a finished write were taken");
	// R10: burst starts at register zero
	a_burst_origin: assert property (s_cmd_end |=> // R10
		((q.burst == (q.cmd[5:1] == IDX_BURST)) && (!q.burst || q.idx == '0)))
		else $error("burst not decoded from index 31 or not started at zero");
	// R22: charger needs a resistor
	a_charger_res: assert property (q.chg[3] |-> q.chg[1:0] != RS_NONE) // R22
		else $error("charger enabled with no resistor");
	// R11: charger never written by a burst
	a_burst_no_tc: assert property ($changed(q.tc) |-> !$past(q.burst)) // R11
		else $error("charger register written by a burst");
	// R12: RAM written only on a RAM data edge
	a_ram_space: assert property ($changed(q.ram) |-> // R12
		$past(sck_rise && q.cmd[CMD_SPACE]))
		else $error("RAM written outside a RAM data edge");
	// R20: lock at command end disables writes
	a_lock_cmd: assert property (s_cmd_end ##0 q.wp |=> !q.wen) // R20
		else $error("write enabled although locked");
	// R15: written time commits at enable fall
	a_fall_commit: assert property ((ce_fall && q.dirty != '0) |=> q.load != '0) // R15
		else $error("written time not committed at enable fall");
endmodule : rtc_serial_top
`default_nettype wire

// file: testbench/host_link.sv
// Host model for the three-wire link: drives enable, serial clock and its data pin side.
// Assumes the bench resolves the data wire (pull-down) and calls tasks from one process.
`timescale 1ns/1ps
`default_nettype none
module host_link (
	input wire logic clk,
	input wire logic io_wire,
	output logic ce,
	output logic sclk,
	output logic host_oe,
	output logic host_d
);
	initial begin
		ce = 1'b0;
		sclk = 1'b0;
		host_oe = 1'b0;
		host_d = 1'b0;
	end
	task start_t();
		sclk = 1'b0;
		ce = 1'b1;
		repeat (4) @(negedge clk);
	endtask : start_t
	// Long idle after the fall so the time load lands before the next frame
	task stop_t();
		repeat (4) @(negedge clk);
		host_oe = 1'b0;
		ce = 1'b0;
		repeat (10) @(negedge clk);
	endtask : stop_t
	task bit_x(input logic drv, input logic b, output logic r);
		host_oe = drv;
		host_d = b;
		repeat (4) @(negedge clk);
		sclk = 1'b1;
		repeat (2) @(negedge clk);
		r = io_wire;
		repeat (2) @(negedge clk);
		sclk = 1'b0;
	endtask : bit_x
	task byte_x(input logic drv, input logic [7:0] w, output logic [7:0] r);
		for (int i = 0; i < 8; i++)
			bit_x(drv, w[i], r[i]);
	endtask : byte_x
endmodule : host_link
`default_nettype wire

// file: testbench/serial_rtc_with_scratch_ram_tb_top.sv
// Bench for the serial timekeeper: table of single accesses, then bursts, abort and rollover.
// Assumes host_link owns the link pins; the data wire has a pull-down when nobody drives.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin num_errors++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module serial_rtc_with_scratch_ram_tb_top import rtc_pkg::*;;
	// Four rising oscillator edges a second keeps rollover waits short
	localparam int OSC_T = 4;
	typedef struct packed {
		logic [7:0] wcmd, wdat, rcmd, rexp;
		logic [3:0] chg;
	} row_s;
	typedef struct packed {
		tbuf_t set;
		tbuf_t exp;
	} cal_s;
	logic clk, srst, osc_in, ce, sclk, host_oe, host_d, io_wire;
	logic io_out, io_oe, charger_on, charger_two;
	logic [1:0] charger_res;
	logic [7:0] bb [8];
	logic [7:0] rb [8];
	int checked, num_errors;
	// Charger nibble is on, two diodes, resistor field
	row_s rows [20] = '{36'h000081800, 36'h00008F000, 36'h0000915C0, 36'h0000C1000,
		36'h8E808F800, 36'hC05AC1000, 36'h90A5915C0, 36'h8E008F000, 36'h8E7F8F000,
		36'hC05AC15A0, 36'hFCA5FDA50, 36'h4033C15A0, 36'h829283920, 36'h927793000,
		36'h90A591A59, 36'h90AB91ABF, 36'h905B915B7, 36'h90AF91AF3, 36'h90A891A84,
		36'h90A691A6A};
	cal_s cal [6] = '{{56'h99071231235959, 56'h00010101000000},
		{56'h04030228235959, 56'h04040229000000},
		{56'h03030228235959, 56'h03040301000000},
		{56'h05020430235959, 56'h05030501000000},
		{56'h05010615B15959, 56'h05020616920000},
		{56'h05010615915959, 56'h05010615B20000}};
	assign io_wire = io_oe ? io_out : (host_oe ? host_d : 1'b0);
	rtc_serial_top #(.OSC_HZ(OSC_T)) DUT (.clk(clk), .srst(srst), .ce(ce), .sclk(sclk),
		.io_in(io_wire), .osc_in(osc_in), .io_out(io_out), .io_oe(io_oe),
		.charger_on(charger_on), .charger_two_diodes(charger_two),
		.charger_resistor(charger_res));
	host_link HOST (.clk(clk), .io_wire(io_wire), .ce(ce), .sclk(sclk), .host_oe(host_oe),
		.host_d(host_d));
	initial clk = 1'b0;
	always #10 clk = ~clk;
	initial osc_in = 1'b0;
	always #2000 osc_in = ~osc_in;
	always @(posedge clk) if (host_oe) `CHK(io_oe, 1'b0)
	task results();
		$display("Counts: %0d checks, %0d errors", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : results
	task bw(input logic [7:0] c, input int n, input int extra);
		logic [7:0] r;
		logic b;
		HOST.start_t();
		HOST.byte_x(1'b1, c, r);
		for (int i = 0; i < n; i++)
			HOST.byte_x(1'b1, bb[i], r);
		for (int i = 0; i < extra; i++)
			HOST.bit_x(1'b1, 1'b1, b);
		HOST.stop_t();
	endtask : bw
	task wr1(input logic [7:0] c, input logic [7:0] d);
		bb[0] = d;
		bw(c, 1, 0);
	endtask : wr1
	task br(input logic [7:0] c, input int n);
		logic [7:0] r;
		HOST.start_t();
		HOST.byte_x(1'b1, c, r);
		for (int i = 0; i < n; i++)
			HOST.byte_x(1'b0, 8'h00, rb[i]);
		HOST.stop_t();
	endtask : br
	initial begin
		repeat (60000) @(posedge clk);
		num_errors++;
		$display("ERROR t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
		results();
	end
	initial begin
		srst = 1'b1;
		checked = 0;
		num_errors = 0;
		repeat (3) @(negedge clk);
		srst = 1'b0;
		repeat (4) @(negedge clk);
		`CHK({charger_on, charger_two, charger_res, io_oe}, 5'h00)
		foreach (rows[i]) begin
			wr1(rows[i].wcmd, rows[i].wdat);
			br(rows[i].rcmd, 1);
			`CHK(rb[0], rows[i].rexp)
			`CHK({charger_on, charger_two, charger_res}, rows[i].chg)
			$display("Row %0d done", i);
		end
		br(8'hFD, 2);
		`CHK({rb[0], rb[1]}, 16'hA5A5)
		// second byte after a single write is ignored
		bb[0] = 8'h11;
		bb[1] = 8'hFF;
		bw(8'hC4, 2, 0);
		br(8'hC5, 1);
		`CHK(rb[0], 8'h11)
		br(8'hC7, 1);
		`CHK(rb[0], 8'h00)
		// partial RAM burst, trailing half byte dropped
		bb[0] = 8'h01;
		bb[1] = 8'h02;
		bb[2] = 8'h03;
		bw(8'hFE, 3, 4);
		br(8'hFF, 4);
		`CHK({rb[0], rb[1], rb[2], rb[3]}, 32'h01020300)
		// enable low in mid-read floats the pin
		HOST.start_t();
		HOST.byte_x(1'b1, 8'h81, rb[0]);
		repeat (3) HOST.bit_x(1'b0, 1'b0, rb[1][0]);
		// Drop the enable while the device drives a bit
		repeat (5) @(negedge clk);
		`CHK(io_oe, 1'b1)
		HOST.ce = 1'b0;
		repeat (8) @(negedge clk);
		`CHK(io_oe, 1'b0)
		br(8'hC1, 1);
		`CHK(rb[0], 8'h01)
		foreach (bb[i]) bb[i] = 8'h05;
		bw(8'hBE, 7, 0);
		br(8'hBF, 3);
		`CHK({rb[0], rb[1], rb[2]}, 24'h809200)
		wr1(8'h8E, 8'h80);
		bb[7] = 8'h00;
		bw(8'hBE, 8, 0);
		br(8'hBF, 8);
		`CHK({rb[0], rb[1], rb[7]}, 24'h809280)
		wr1(8'h8E, 8'h00);
		$display("Burst, abort and lock tests done");
		// set halted, then a seconds write starts a fresh second
		foreach (cal[i]) begin
			for (int k = 0; k < 7; k++)
				bb[k] = cal[i].set[k];
			bb[0] = bb[0] | 8'h80;
			bb[7] = 8'h00;
			bw(8'hBE, 8, 0);
			wr1(8'h80, cal[i].set[0]);
			repeat (1200) @(negedge clk);
			br(8'hBF, 8);
			for (int k = 0; k < 7; k++)
				`CHK(rb[k], cal[i].exp[k])
			`CHK(rb[7], 8'h00)
			$display("Calendar case %0d done", i);
		end
		// Reset in mid-run: charger off again and clock halted
		srst = 1'b1;
		repeat (3) @(negedge clk);
		srst = 1'b0;
		repeat (4) @(negedge clk);
		`CHK({charger_on, charger_two, charger_res}, 4'h0)
		br(8'h81, 1);
		`CHK(rb[0], 8'h80)
		$display("Mid-run reset test done");
		results();
	end
endmodule : serial_rtc_with_scratch_ram_tb_top
`undef CHK
`default_nettype wire
